// ===== shared/ppc_params.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * pulse/period capture block, as macros.
 * assumes a 32-bit register bus with byte addresses, one word per register.
 */
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

// structure sizes
`define PPC_NUM_PINS 4
`define PPC_NUM_SLOTS 4
`define PPC_HR_BITS 7
`define PPC_LOOP_BITS 25

// timing: one high-res tick per core clock, loop period of 2**HR_BITS ticks
`define PPC_CLK_PERIOD_NS 25
`define PPC_LOOP_CYCLES (1 << `PPC_HR_BITS)
`define PPC_HR_HALF 32'h0000_0040
`define PPC_HR_MASK 32'h0000_007F

// register word indices, taken from byte address bits 5:2
`define PPC_OFS_SHARE 4'h0
`define PPC_OFS_PINS 4'h1
`define PPC_OFS_VALID 4'h2
`define PPC_OFS_NOW 4'h3
`define PPC_OFS_CFG0 4'h4
`define PPC_OFS_RES0 4'h8

// share control fields
`define PPC_SHARE_PAIR_BIT 1
`define PPC_GPIO3_OUT_BIT 8
`define PPC_GPIO3_DRIVE_BIT 9

// slot config fields
`define PPC_CFG_EN_BIT 0
`define PPC_CFG_OP_BIT 1
`define PPC_CFG_TYPE_BIT 2
`define PPC_CFG_RES_BIT 3
`define PPC_CFG_PIN_LSB 4

// reset values
`define PPC_RST_WORD 32'h0000_0000

`endif

// ===== shared/ppc_pkg.sv
/*
 * types of the pulse/period capture block.
 * assumes ppc_params.svh is on the include path.
 */
`default_nettype none
`include "ppc_params.svh"

package ppc_pkg;

	typedef enum logic {
		period_pulse_count_op = 1'b0,
		wide_capture_op = 1'b1
	} ppc_op_type;

	typedef enum logic {
		rising_to_falling_type = 1'b0,
		falling_to_falling_type = 1'b1
	} ppc_edge_type;

	typedef enum logic {
		loop_res = 1'b0,
		high_res = 1'b1
	} ppc_res_type;

	typedef struct packed {
		logic [1:0] pin;
		ppc_res_type resolution_select;
		ppc_edge_type edge_pair;
		ppc_op_type op;
		logic en;
	} ppc_cfg_type;

	typedef struct packed {
		logic [`PPC_LOOP_BITS-1:0] loop_cnt;
		logic [`PPC_HR_BITS-1:0] hr_cnt;
		logic [`PPC_NUM_PINS-1:0] tin_prev;
		ppc_cfg_type [`PPC_NUM_SLOTS-1:0] cfg;
		logic [`PPC_NUM_SLOTS-1:0] armed;
		logic [`PPC_NUM_SLOTS-1:0][31:0] start;
		logic [`PPC_NUM_SLOTS-1:0][31:0] result;
		logic [`PPC_NUM_SLOTS-1:0] valid;
		logic share;
		logic gpio3_out;
		logic gpio3_drive;
		logic waitreq;
		logic [31:0] rdata;
	} ppc_state_type;

endpackage

`default_nettype wire

// ===== rtl/ppc_capture.sv
/*
 * pulse/period capture block: timer input pins, per-pin high-res
 * structure, four capture slots and an avalon-mm register slave.
 * assumes pin inputs synchronous to core_clk; high-res tick = core_clk.
 * assumes the bus master holds each request until it sees waitrequest low.
 * a high-res request on a pin already owned falls back to loop resolution.
 */
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
// Behaviour
// [RULE1] several capture slots may measure one pin, each with its own result
// [RULE2] per pin only one slot gets high resolution; others run at loop resolution
// [RULE3] high-res result exact to half a high-res tick, quantization only
// [RULE4] loop-resolution results read zero in bits 6:0, always
// [RULE5] loop-resolution result within half a loop period of true value
// [RULE6] share pair bit routes device pin 2 to timer inputs 2 and 3
// [RULE7] while sharing, pin 3 structure serves pin 2; pin 3 is gpio only
// [RULE8] both edges inside one loop period still give a correct capture
// [RULE9] second edge at loop-period start still captures the high-res value
// [RULE10] edge type picks rise-to-fall pulse width or fall-to-fall period
// [RULE11] captures on one pin in one loop period never mix resolution paths
`timescale 1ns/100ps
`default_nettype none
`include "ppc_params.svh"

module ppc_capture (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [`PPC_NUM_PINS-1:0] pin_in,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic gpio3_out,
	output logic gpio3_oe_n
);
	import ppc_pkg::*;

	ppc_state_type st_reg;
	ppc_state_type st_next;
	logic [`PPC_NUM_PINS-1:0] tin;
	logic [`PPC_NUM_PINS-1:0] rise;
	logic [`PPC_NUM_PINS-1:0] fall;
	logic [`PPC_NUM_SLOTS-1:0] hr_grant;
	logic [31:0] now;
	logic [3:0] word;
	logic bus_take;
	logic [`PPC_NUM_SLOTS-1:0] slot_end;

	// merge written bytes into a register word
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// nearest loop boundary, low bits cleared; keeps the error within half a loop
	function automatic logic [31:0] loop_round(input logic [31:0] v);
		logic [31:0] r;
		r = v + `PPC_HR_HALF;
		return r & ~`PPC_HR_MASK;
	endfunction

	// timer inputs: with sharing, pin 2 drives both inputs 2 and 3
	always_comb begin
		tin = pin_in;
		if (st_reg.share) begin
			tin[3] = pin_in[2]; // RULE6 RULE7
		end
	end

	assign rise = tin & ~st_reg.tin_prev;
	assign fall = ~tin & st_reg.tin_prev;
	assign now = {st_reg.loop_cnt, st_reg.hr_cnt};
	assign word = avs_address[5:2];
	assign bus_take = (avs_read | avs_write) & ~st_reg.waitreq;

	// one high-res structure per pin: lowest enabled high-res slot owns it
	always_comb begin
		hr_grant = '0;
		for (int s = 0; s < `PPC_NUM_SLOTS; s++) begin
			hr_grant[s] = st_reg.cfg[s].en && st_reg.cfg[s].resolution_select == high_res; // RULE2
			for (int j = 0; j < s; j++) begin
				if (st_reg.cfg[j].en && st_reg.cfg[j].resolution_select == high_res &&
					st_reg.cfg[j].pin == st_reg.cfg[s].pin) begin
					hr_grant[s] = 1'b0; // RULE2
				end
			end
		end
	end

	// a slot ends a measurement on a fall of its pin while armed
	always_comb begin
		slot_end = '0;
		for (int s = 0; s < `PPC_NUM_SLOTS; s++) begin
			slot_end[s] = st_reg.armed[s] && st_reg.cfg[s].en && fall[st_reg.cfg[s].pin]; // RULE8
		end
	end

	// next state: time base, capture slots, register slave
	always_comb begin
		logic [1:0] p;
		logic start_edge;
		logic [31:0] value;
		st_next = st_reg;
		p = 2'd0;
		start_edge = 1'b0;
		value = '0;
		// time stamp and loop tick advance together, so a tick edge is never split
		{st_next.loop_cnt, st_next.hr_cnt} = now + 32'h0000_0001; // RULE9
		st_next.tin_prev = tin;
		for (int s = 0; s < `PPC_NUM_SLOTS; s++) begin
			p = st_reg.cfg[s].pin;
			if (st_reg.cfg[s].edge_pair == rising_to_falling_type) begin
				start_edge = rise[p]; // RULE10
			end else begin
				start_edge = fall[p]; // RULE10
			end
			if (!st_reg.cfg[s].en) begin
				st_next.armed[s] = 1'b0;
			end else if (!st_reg.armed[s]) begin
				if (start_edge) begin
					st_next.armed[s] = 1'b1;
					st_next.start[s] = now; // RULE8
				end
			end else if (fall[p]) begin
				// each slot has its own start and result, so slots never interfere
				if (st_reg.cfg[s].op == wide_capture_op) begin
					value = now; // RULE1
				end else begin
					value = now - st_reg.start[s]; // RULE1 RULE8
				end
				if (hr_grant[s]) begin
					st_next.result[s] = value; // RULE3 RULE11
				end else begin
					st_next.result[s] = loop_round(value); // RULE4 RULE5 RULE11
				end
				st_next.valid[s] = 1'b1;
				st_next.start[s] = now;
				st_next.armed[s] = st_reg.cfg[s].edge_pair == falling_to_falling_type; // RULE10
			end
		end
		// avalon slave: one wait cycle, then the access completes
		if ((avs_read | avs_write) && st_reg.waitreq) begin
			st_next.waitreq = 1'b0;
			st_next.rdata = '0;
			if (word == `PPC_OFS_SHARE) begin
				st_next.rdata[`PPC_SHARE_PAIR_BIT] = st_reg.share;
				st_next.rdata[`PPC_GPIO3_OUT_BIT] = st_reg.gpio3_out;
				st_next.rdata[`PPC_GPIO3_DRIVE_BIT] = st_reg.gpio3_drive;
			end else if (word == `PPC_OFS_PINS) begin
				st_next.rdata[7:0] = {pin_in, tin};
			end else if (word == `PPC_OFS_VALID) begin
				st_next.rdata[`PPC_NUM_SLOTS-1:0] = st_reg.valid;
			end else if (word == `PPC_OFS_NOW) begin
				st_next.rdata = now;
			end else if (word >= `PPC_OFS_CFG0 && word < `PPC_OFS_RES0) begin
				st_next.rdata[5:0] = st_reg.cfg[word[1:0]];
			end else if (word >= `PPC_OFS_RES0 && word < `PPC_OFS_RES0 + 4'h4) begin
				st_next.rdata = st_reg.result[word[1:0]];
			end
		end else if (bus_take) begin
			st_next.waitreq = 1'b1;
			if (avs_write) begin
				if (word == `PPC_OFS_SHARE) begin
					value = be_merge({22'd0, st_reg.gpio3_drive, st_reg.gpio3_out, 6'd0,
						st_reg.share, 1'b0}, avs_writedata, avs_byteenable);
					st_next.share = value[`PPC_SHARE_PAIR_BIT]; // RULE6
					st_next.gpio3_out = value[`PPC_GPIO3_OUT_BIT];
					st_next.gpio3_drive = value[`PPC_GPIO3_DRIVE_BIT];
				end else if (word == `PPC_OFS_VALID && avs_byteenable[0]) begin
					// a result landing in this very cycle keeps its flag: the set wins
					for (int s = 0; s < `PPC_NUM_SLOTS; s++) begin
						if (avs_writedata[s] && !slot_end[s]) begin
							st_next.valid[s] = 1'b0;
						end
					end
				end else if (word >= `PPC_OFS_CFG0 && word < `PPC_OFS_RES0) begin
					value = be_merge({26'd0, st_reg.cfg[word[1:0]]}, avs_writedata, avs_byteenable);
					st_next.cfg[word[1:0]] = ppc_cfg_type'(value[5:0]);
				end
			end
		end
	end

	// single state register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0;
			st_reg.waitreq <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register; pin 3 drives only while shared
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.waitreq;
	assign gpio3_out = st_reg.gpio3_out;
	assign gpio3_oe_n = ~(st_reg.share & st_reg.gpio3_drive); // RULE7

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_share_route: assert property (st_reg.share |-> tin[3] == pin_in[2]) // RULE6
		else $error("shared input 3 not driven by pin 2");
	a_gpio_only: assert property (!st_reg.share |-> gpio3_oe_n) // RULE7
		else $error("pin 3 driven while not shared");
	a_loop_tick: assert property (st_reg.hr_cnt == 7'h7F |=> st_reg.hr_cnt == 7'h00 && // RULE5
		st_reg.loop_cnt == $past(st_reg.loop_cnt) + 25'd1)
		else $error("loop period is not 128 ticks");
	// the slave answers one cycle after it first sees a request
	a_bus_answer: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest ##1
		avs_waitrequest)
		else $error("bus answer not in one cycle");
	// the answer stands for one cycle only
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	// read data stand between accesses, so a late sampler still sees them
	a_rdata_hold: assert property (!(avs_read | avs_write) |=> $stable(avs_readdata))
		else $error("read data changed without an access");
	// pin 3 drives whenever sharing and its drive bit are both set
	a_gpio_drive: assert property (st_reg.share && st_reg.gpio3_drive |-> !gpio3_oe_n) // RULE7
		else $error("pin 3 not driven while shared");
	// the share bit reads back as it stands
	a_share_read: assert property (avs_read && avs_waitrequest && // RULE6
		avs_address[5:2] == `PPC_OFS_SHARE |=> avs_readdata[`PPC_SHARE_PAIR_BIT] == $past(st_reg.share))
		else $error("share bit reads back wrong");
	// the flag word reads back the flags as they stood when the read was seen
	a_valid_read: assert property (avs_read && avs_waitrequest && avs_address[5:2] == `PPC_OFS_VALID |=>
		avs_readdata[`PPC_NUM_SLOTS-1:0] == $past(st_reg.valid))
		else $error("valid flags read back wrong");

	generate
		for (genvar g = 0; g < `PPC_NUM_SLOTS; g++) begin : chk
			// a loop-resolution result never carries fraction bits
			a_lr_low_zero: assert property ($rose(st_reg.valid[g]) && !$past(hr_grant[g]) |-> // RULE4
				st_reg.result[g][6:0] == 7'h00)
				else $error("loop result has fraction bits");
			// the owner of the structure counts exact ticks
			a_hr_exact: assert property (st_reg.armed[g] && st_reg.cfg[g].en && // RULE3
				fall[st_reg.cfg[g].pin] && hr_grant[g] && st_reg.cfg[g].op == period_pulse_count_op |=>
				st_reg.result[g] == $past(now) - $past(st_reg.start[g]))
				else $error("high-res count wrong");
			// an end edge on the first tick of a loop period keeps its fraction
			a_edge_at_tick: assert property (st_reg.armed[g] && st_reg.cfg[g].en && // RULE9
				fall[st_reg.cfg[g].pin] && hr_grant[g] && st_reg.hr_cnt == 7'h00 &&
				st_reg.cfg[g].op == wide_capture_op |=> st_reg.result[g] == $past(now))
				else $error("stamp at loop start wrong");
			// no end edge is lost, not even to a flag clear in the same cycle
			a_short_pulse: assert property (st_reg.armed[g] && st_reg.cfg[g].en && // RULE8
				fall[st_reg.cfg[g].pin] |=> st_reg.valid[g])
				else $error("capture lost");
			a_rise_arms: assert property (!st_reg.armed[g] && st_reg.cfg[g].en && // RULE10
				st_reg.cfg[g].edge_pair == rising_to_falling_type && !rise[st_reg.cfg[g].pin] |=>
				!st_reg.armed[g])
				else $error("pulse width armed without rise");
			// a rise stamps the start of a pulse-width slot
			a_rise_stamp: assert property (!st_reg.armed[g] && st_reg.cfg[g].en && // RULE8
				st_reg.cfg[g].edge_pair == rising_to_falling_type && rise[st_reg.cfg[g].pin] |=>
				st_reg.armed[g] && st_reg.start[g] == $past(now))
				else $error("pulse start not stamped");
			// a pulse-width slot waits for the next rise after its fall
			a_pulse_rest: assert property (slot_end[g] && // RULE10
				st_reg.cfg[g].edge_pair == rising_to_falling_type |=> !st_reg.armed[g])
				else $error("pulse width slot still armed after its fall");
			// each fall of a period slot ends one period and starts the next
			a_period_chain: assert property (slot_end[g] && // RULE10
				st_reg.cfg[g].edge_pair == falling_to_falling_type |=>
				st_reg.armed[g] && st_reg.start[g] == $past(now))
				else $error("period chain broken");
			// rounding keeps a loop-resolution count within half a loop period
			a_lr_near: assert property (slot_end[g] && !hr_grant[g] && // RULE5
				st_reg.cfg[g].op == period_pulse_count_op |=>
				st_reg.result[g] - ($past(now) - $past(st_reg.start[g])) + 32'h0000_0040 < 32'h0000_0080)
				else $error("loop count off by more than half a loop");
			// a disabled slot keeps its result while other slots capture
			a_slot_apart: assert property (!st_reg.cfg[g].en |=> $stable(st_reg.result[g])) // RULE1
				else $error("idle slot result disturbed");
			// disabling a slot drops its arming
			a_disarm_off: assert property (!st_reg.cfg[g].en |=> !st_reg.armed[g])
				else $error("disabled slot still armed");
			// writing one clears a flag unless a result lands in that cycle
			a_flag_clear: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] &&
				avs_address[5:2] == `PPC_OFS_VALID && avs_writedata[g] && !slot_end[g] |=>
				!st_reg.valid[g])
				else $error("valid flag not cleared");
			a_one_owner: assert property (hr_grant[g] |-> (hr_grant & ~(4'b0001 << g)) == 4'h0 || // RULE2
				st_reg.cfg[0].pin != st_reg.cfg[g].pin || g == 0)
				else $error("second owner of hi-res structure");
		end
	endgenerate

endmodule

`default_nettype wire

// ===== testbench/ppc_pulse_src.sv
/*
 * pulse source model standing in for the external signal on one timer pin.
 * assumes the bench holds run low while it reconfigures capture slots.
 */
`timescale 1ns/100ps
`default_nettype none
module ppc_pulse_src #(
	parameter int HI = 5,
	parameter int LO = 200,
	parameter int LANE = 2
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic run,
	output logic [3:0] wave
);
	int cnt;
	logic lvl;
	// high for HI cycles, low for LO; the short high puts both edges in one loop period
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			lvl <= 1'b0;
		end else if (!run) begin
			cnt <= 0;
			lvl <= 1'b0;
		end else if (cnt == (lvl ? HI : LO) - 1) begin
			cnt <= 0;
			lvl <= !lvl;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// only the chosen lane toggles, the other pins rest low
	assign wave = 4'(lvl) << LANE;
endmodule
`default_nettype wire

// ===== testbench/pulse_period_capture_test.sv
/*
 * self-checking bench of the capture block: avalon tasks and measurement tests.
 * assumes ppc_pkg and the pulse source model are compiled before this file.
 */
`timescale 1ns/100ps
`default_nettype none
module pulse_period_capture_test;
	import ppc_pkg::*;
	localparam logic [31:0] PW = 32'h0000_0005;
	localparam logic [31:0] PER = 32'h0000_00CD;
	localparam logic [31:0] LRM = 32'hFFFF_FF80;
	logic core_clk, reset_n, run, avs_read, avs_write, avs_waitrequest, gpio3_out, gpio3_oe_n;
	logic [3:0] wave, extra, pin_in;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, res0, res1;
	int err_total, total_checks;
	// raw pin 3 can be pulled high by the bench to show it is ignored while shared
	assign pin_in = wave | extra;
	ppc_capture ppc_capture_i (.core_clk(core_clk), .reset_n(reset_n), .pin_in(pin_in),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .gpio3_out(gpio3_out), .gpio3_oe_n(gpio3_oe_n));
	ppc_pulse_src ppc_pulse_src_i (.core_clk(core_clk), .reset_n(reset_n), .run(run), .wave(wave));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one access; an edge passes first so release and next request never share a step
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// hold until waitrequest is seen low; only the watchdog ends a hang
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	function automatic ppc_cfg_type mk(input logic [1:0] p, input ppc_res_type r, input ppc_edge_type e,
		input ppc_op_type o);
		mk = '{p, r, e, o, 1'b1};
	endfunction
	// second round after a clear so stale arming from earlier setups cannot leak in
	task automatic meas(input ppc_cfg_type c0, input ppc_cfg_type c1);
		int n;
		run <= 1'b0;
		bus(1'b1, 6'h10, 32'(c0));
		bus(1'b1, 6'h14, 32'(c1));
		run <= 1'b1;
		repeat (2) begin
			bus(1'b1, 6'h08, 32'h0000_000F);
			bus(1'b0, 6'h08, 32'h0);
			chk(rd & 32'h3, 32'h0);
			n = 0;
			while (rd[1:0] !== 2'b11 && n < 300) begin
				bus(1'b0, 6'h08, 32'h0);
				n++;
			end
			chk(rd & 32'h3, 32'h3);
		end
		bus(1'b0, 6'h20, 32'h0);
		res0 = rd;
		bus(1'b0, 6'h24, 32'h0);
		res1 = rd;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = !core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		close_out();
	end
	initial begin
		reset_n = 1'b0;
		run = 1'b0;
		extra = 4'h0;
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		err_total = 0;
		total_checks = 0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		chk(32'(gpio3_oe_n), 32'h1);
		bus(1'b0, 6'h00, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 6'h30, 32'h0);
		chk(rd, 32'h0);
		// both high-res on one pin: lower slot keeps the structure
		meas(mk(2'd2, high_res, rising_to_falling_type, period_pulse_count_op),
			mk(2'd2, high_res, falling_to_falling_type, period_pulse_count_op));
		chk(res0, PW);
		chk(res1, (PER + 32'h40) & LRM);
		// loop-res r2f beside a high-res f2f on the same pin
		meas(mk(2'd2, loop_res, rising_to_falling_type, period_pulse_count_op),
			mk(2'd2, high_res, falling_to_falling_type, period_pulse_count_op));
		chk(res0, (PW + 32'h40) & LRM);
		chk(res1, PER);
		// share the pair: pin 3 structure measures pin 2, raw pin 3 ignored
		run <= 1'b0;
		extra <= 4'h8;
		bus(1'b1, 6'h00, 32'h0000_0302);
		@(posedge core_clk);
		chk({30'h0, gpio3_oe_n, gpio3_out}, 32'h1);
		bus(1'b0, 6'h04, 32'h0);
		chk(rd & 32'hFF, 32'h80);
		meas(mk(2'd2, high_res, rising_to_falling_type, period_pulse_count_op),
			mk(2'd3, high_res, falling_to_falling_type, period_pulse_count_op));
		chk(res0, PW);
		chk(res1, PER);
		run <= 1'b0;
		bus(1'b1, 6'h00, 32'h0000_0200);
		@(posedge core_clk);
		chk(32'(gpio3_oe_n), 32'h1);
		// wide capture: loop-res stamp keeps its fraction bits clear
		meas(mk(2'd2, high_res, falling_to_falling_type, wide_capture_op),
			mk(2'd2, loop_res, falling_to_falling_type, wide_capture_op));
		chk(res1 & 32'h7F, 32'h0);
		chk(res1, (res0 + 32'h40) & LRM);
		close_out();
	end
endmodule
`default_nettype wire
